// ===== src/ieb_pkg.sv
// package for the interrupt enable bank: register map, masks, reset values
// assumes an apb master with 32-bit data on the system clock
package ieb_pkg;
  localparam int APB_AW = 8;
  localparam int NWORD = 3;
  localparam int NSRC = 48;
  localparam int PRIO_W = 3;
  localparam int PRIO_REGS = 12;
  // word offsets (byte addresses)
  localparam logic [APB_AW-1:0] OFF_EN = 8'h00;
  localparam logic [APB_AW-1:0] OFF_FLAG = 8'h10;
  localparam logic [APB_AW-1:0] OFF_PRIO = 8'h20;
  localparam logic [APB_AW-1:0] OFF_END = 8'h50;
  localparam logic [APB_AW-1:0] FLAG_SPAN = 8'h10;
  // implemented bits per enable word, word 1 lowest
  localparam logic [15:0] MASK_WORD1 = 16'h000b;
  localparam logic [15:0] MASK_WORD2 = 16'hdfff;
  localparam logic [15:0] MASK_WORD3 = 16'ha7ff;
  localparam logic [NSRC-1:0] IMPL_MASK = {MASK_WORD3, MASK_WORD2, MASK_WORD1};
  localparam logic [15:0] EN_RESET = 16'h0000;
  localparam logic [15:0] FLAG_RESET = 16'h0000;
  localparam logic [PRIO_W-1:0] PRIO_RESET = 3'h4;
  localparam logic [PRIO_W-1:0] PRIO_OFF = 3'h0;
  localparam int PRIO_STRIDE = 4;
  // register kinds seen by the decoder
  typedef enum logic [1:0] {
    KIND_EN = 2'b00,
    KIND_FLAG = 2'b01,
    KIND_PRIO = 2'b11,
    KIND_NONE = 2'b10
  } ieb_kind_e;
  typedef struct packed {
    ieb_kind_e kind;
    logic [3:0] idx;
  } ieb_dec_s;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [APB_AW-1:0] paddr;
    logic [31:0] pwdata;
  } ieb_apb_req_s;
endpackage

// ===== src/ieb_word_slice.sv
// one 16-bit enable word with its flags and gated requests
// assumes strobes and events on the same clock as the bank
`timescale 1ns/1ps
`default_nettype none
module ieb_word_slice import ieb_pkg::*; #(
  parameter logic [15:0] MASK = 16'hffff
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic en_we,
  input wire logic flag_we,
  input wire logic [15:0] wdata,
  input wire logic [15:0] src_event,
  input wire logic [15:0] prio_ok,
  output logic [15:0] enable,
  output logic [15:0] flag,
  output logic [15:0] req
);
  always_ff @(posedge clock) begin
    if (rst) begin
      enable <= EN_RESET;
    end else if (ce && en_we) begin
      enable <= wdata & MASK;
    end
  end

  // flag sets whatever the enable; set beats clear
  always_ff @(posedge clock) begin
    if (rst) begin
      flag <= FLAG_RESET;
    end else if (ce) begin
      flag <= ((flag_we ? wdata : flag) | src_event) & MASK;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      req <= FLAG_RESET;
    end else if (ce) begin
      req <= flag & enable & prio_ok & MASK;
    end
  end

  a_req_gated: assert property (
    @(posedge clock) disable iff (rst)
    (ce && (flag & enable & prio_ok) == 16'h0000) |=> req == 16'h0000
  ) else $error("request raised without flag, enable and priority");
  a_unimpl_zero: assert property (
    @(posedge clock) disable iff (rst)
    ((enable | flag | req) & ~MASK) == 16'h0000
  ) else $error("unimplemented bit holds a one");
  a_set_wins: assert property (
    @(posedge clock) disable iff (rst)
    (ce && flag_we && (src_event & MASK) != 16'h0000)
      |=> (flag & $past(src_event) & MASK) == ($past(src_event) & MASK)
  ) else $error("source event lost to a flag write");
  a_reset_clear: assert property (
    @(posedge clock) rst |=> enable == EN_RESET && req == FLAG_RESET
  ) else $error("enable or request not clear after reset");
endmodule // ieb_word_slice
`default_nettype wire

// ===== src/ieb_top.sv
// interrupt enable bank: three enable words, flags, priorities, apb slave
// assumes apb master on the same clock; source events are same-clock pulses
//
// Summary of operation
// - an enable bit of one passes its source request, zero blocks it
// - enable bits are read/write and clear at reset
// - unimplemented bit positions always read back as zero
// - word 1 bits 3,1,0: pin change, twowire1 master, slave; bit 2 empty
// - word 2 high byte: timer6, xfer4, empty, compare8..5, capture6
// - word 2 low byte: capture5..3, xfer3, canbus1 event/rx, serial2 event/err
// - word 3 high: fault a, xfer5, encoder, pwm error, canbus2; 14,12,11 empty
// - word 3 low: canbus2 rx, ext4/3, timer9/8, twowire2 m/s, timer7
// - each source has a flag that reads one once it has requested
// - a three-bit priority of zero disables the source, seven is highest
`timescale 1ns/1ps
`default_nettype none
module ieb_top import ieb_pkg::*; #(
  parameter logic [PRIO_W-1:0] PRIO_INIT = PRIO_RESET
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire ieb_apb_req_s apb,
  input wire logic [NSRC-1:0] src_event,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  output logic [NSRC-1:0] irq_req
);
  if (PRIO_INIT == PRIO_OFF) begin : g_bad_prio
    $error("reset priority must not disable the sources");
  end

  logic [PRIO_W-1:0] prio [NSRC];
  logic [NSRC-1:0] prio_ok;
  logic [NSRC-1:0] en_all;
  logic [NSRC-1:0] flag_all;
  ieb_dec_s dec;
  logic access;
  logic wr_fire;

  // map a byte address onto a register kind and word index
  function automatic ieb_dec_s decode(input logic [APB_AW-1:0] a);
    ieb_dec_s d;
    logic [APB_AW-1:0] rel;
    d.kind = KIND_NONE;
    d.idx = 4'h0;
    rel = 8'h00;
    if (a[1:0] == 2'b00) begin
      if (a < OFF_EN + 8'(NWORD * 4)) begin
        d.kind = KIND_EN;
        rel = a - OFF_EN;
      end else if (a >= OFF_FLAG && a < OFF_FLAG + 8'(NWORD * 4)) begin
        d.kind = KIND_FLAG;
        rel = a - OFF_FLAG;
      end else if (a >= OFF_PRIO && a < OFF_END) begin
        d.kind = KIND_PRIO;
        rel = a - OFF_PRIO;
      end
      d.idx = rel[5:2];
    end
    return d;
  endfunction

  // pack the four priority fields of one priority register
  function automatic logic [15:0] prio_word(input logic [3:0] k,
      input logic [NSRC*PRIO_W-1:0] p);
    logic [15:0] w;
    int s;
    w = 16'h0000;
    for (int j = 0; j < PRIO_STRIDE; j++) begin
      s = int'(k) * PRIO_STRIDE + j;
      if (IMPL_MASK[s]) begin
        w[j*PRIO_STRIDE +: PRIO_W] = p[s*PRIO_W +: PRIO_W];
      end
    end
    return w;
  endfunction

  assign dec = decode(apb.paddr);
  assign access = apb.psel && apb.penable;
  assign wr_fire = access && pready && apb.pwrite;

  // flatten priorities for the read function
  logic [NSRC*PRIO_W-1:0] prio_flat;
  always_comb begin
    for (int i = 0; i < NSRC; i++) begin
      prio_flat[i*PRIO_W +: PRIO_W] = prio[i];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < NSRC; i++) begin
        prio[i] <= PRIO_INIT;
      end
    end else if (ce && wr_fire && dec.kind == KIND_PRIO) begin
      for (int i = 0; i < NSRC; i++) begin
        if (i / PRIO_STRIDE == int'(dec.idx) && IMPL_MASK[i]) begin
          prio[i] <= apb.pwdata[(i % PRIO_STRIDE) * PRIO_STRIDE +: PRIO_W];
        end
      end
    end
  end

  // source passes only with nonzero priority
  always_comb begin
    for (int i = 0; i < NSRC; i++) begin
      prio_ok[i] = IMPL_MASK[i] && (prio[i] != PRIO_OFF);
    end
  end

  for (genvar w = 0; w < NWORD; w++) begin : g_word
    ieb_word_slice #(
      .MASK(IMPL_MASK[w*16 +: 16])
    ) u_slice (
      .clock(clock),
      .rst(rst),
      .ce(ce),
      .en_we(wr_fire && dec.kind == KIND_EN && int'(dec.idx) == w),
      .flag_we(wr_fire && dec.kind == KIND_FLAG && int'(dec.idx) == w),
      .wdata(apb.pwdata[15:0]),
      .src_event(src_event[w*16 +: 16]),
      .prio_ok(prio_ok[w*16 +: 16]),
      .enable(en_all[w*16 +: 16]),
      .flag(flag_all[w*16 +: 16]),
      .req(irq_req[w*16 +: 16])
    );
  end

  // apb answer: pready one cycle into the access phase
  always_ff @(posedge clock) begin
    if (rst) begin
      pready <= 1'b0;
    end else if (ce) begin
      pready <= access && !pready;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (ce && access && !pready) begin
      pslverr <= dec.kind == KIND_NONE;
      prdata <= 32'h0000_0000;
      if (!apb.pwrite) begin
        case (dec.kind)
          KIND_EN: prdata[15:0] <= en_all[int'(dec.idx)*16 +: 16];
          KIND_FLAG: prdata[15:0] <= flag_all[int'(dec.idx)*16 +: 16];
          KIND_PRIO: prdata[15:0] <= prio_word(dec.idx, prio_flat);
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  sequence s_apb_setup;
    apb.psel && !apb.penable;
  endsequence
  sequence s_apb_wait;
    apb.psel && apb.penable && !pready;
  endsequence

  a_apb_ready_one: assert property (
    @(posedge clock) disable iff (rst || !ce)
    s_apb_setup ##1 s_apb_wait |=> pready
  ) else $error("pready not raised in the second access cycle");
  a_apb_ready_pulse: assert property (
    @(posedge clock) disable iff (rst || !ce)
    pready |=> !pready
  ) else $error("pready held longer than one cycle");
  a_unmapped_err: assert property (
    @(posedge clock) disable iff (rst || !ce)
    (s_apb_wait and dec.kind == KIND_NONE) |=> pslverr && pready
  ) else $error("unmapped address answered without error");
  a_en_readback: assert property (
    @(posedge clock) disable iff (rst || !ce)
    (wr_fire && dec.kind == KIND_EN && dec.idx == 4'h1)
      |=> 32'(en_all[31:16]) == ($past(apb.pwdata) & 32'(MASK_WORD2))
  ) else $error("enable word two did not take the write");
  a_prio_block: assert property (
    @(posedge clock) disable iff (rst || !ce)
    (prio[16] == PRIO_OFF) |=> !irq_req[16]
  ) else $error("source with priority zero still requested");
  a_read_zero_high: assert property (
    @(posedge clock) disable iff (rst)
    pready |-> prdata[31:16] == 16'h0000
  ) else $error("upper read bits not zero");

  // looked back on by the checks below
  logic [NSRC-1:0] gate_want;
  logic [15:0] flag_low;
  assign gate_want = flag_all & en_all & prio_ok;
  assign flag_low = flag_all[15:0];

  sequence s_flag_read;
    s_apb_wait and (ce && !apb.pwrite && dec.kind == KIND_FLAG
      && dec.idx == 4'h0);
  endsequence

  // request register tracks flag, enable and priority
  a_irq_follows: assert property (
    @(posedge clock) disable iff (rst || !ce)
    ce |=> irq_req == $past(gate_want)
  ) else $error("request does not follow flag, enable and priority");
  // a priority write lands in its field
  a_prio_write: assert property (
    @(posedge clock) disable iff (rst || !ce)
    (ce && wr_fire && dec.kind == KIND_PRIO && dec.idx == 4'h4)
      |=> prio[16] == PRIO_W'($past(apb.pwdata))
  ) else $error("priority write did not reach its field");
  // flag word one reads back the flags
  a_flag_read: assert property (
    @(posedge clock) disable iff (rst || !ce)
    s_flag_read |=> prdata[15:0] == $past(flag_low)
  ) else $error("flag word one read back wrong");
  a_mapped_ok: assert property (
    @(posedge clock) disable iff (rst || !ce)
    (s_apb_wait and (ce && dec.kind != KIND_NONE)) |=> !pslverr && pready
  ) else $error("mapped address answered with an error");
endmodule // ieb_top
`default_nettype wire

// ===== verif/interrupt_enable_bank_tb.sv
// self-checking bench for the interrupt enable bank, apb master inside
// assumes ieb_pkg and ieb_top are compiled first; one 40 MHz clock
`timescale 1ns/1ps
`default_nettype none
module interrupt_enable_bank_tb import ieb_pkg::*;;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  ieb_apb_req_s apb = '0;
  logic [NSRC-1:0] src_event = '0;
  logic pready;
  logic pslverr;
  logic [31:0] prdata;
  logic [NSRC-1:0] irq_req;
  int err_total = 0;
  int compares = 0;
  logic [31:0] rd;
  logic err_seen;
  logic [15:0] en_val [3];
  logic [NSRC-1:0] ev;
  logic [7:0] bad_addr [3] = '{8'h0c, 8'h02, 8'h60};

  // 25 ns period
  always #12.5 clock = ~clock;

  ieb_top dut (
    .clock(clock), .rst(rst), .ce(ce), .apb(apb), .src_event(src_event),
    .pready(pready), .pslverr(pslverr), .prdata(prdata), .irq_req(irq_req)
  );

  // compare and count
  task automatic check(input string what, input logic [NSRC-1:0] seen,
                       input logic [NSRC-1:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s exp %h seen %h", what, exp, seen);
    end
  endtask

  // one apb transfer, held until pready is seen high at an edge
  task automatic apb_xfer(input logic wr, input logic [7:0] addr,
                          input logic [31:0] data);
    @(posedge clock);
    apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr,
             pwdata: data};
    @(posedge clock);
    apb.penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    err_seen = pslverr;
    apb <= '0;
    check("pready", 48'(pready), 48'h1);
  endtask

  // verdict and end of run
  task automatic complete_run();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clock);
    err_total++;
    complete_run();
  end

  // main sequence
  initial begin
    int i;
    int w;
    logic [15:0] d;
    void'($urandom(32'h8640ba47));
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    for (w = 0; w < NWORD; w++) begin
      apb_xfer(1'b0, OFF_EN + 8'(4*w), '0);
      check("enable reset", 48'(rd), '0);
      apb_xfer(1'b0, OFF_FLAG + 8'(4*w), '0);
      check("flag reset", 48'(rd), '0);
    end
    check("irq reset", irq_req, '0);
    $display("test reset done");
    // readback, all ones first, then random words
    for (i = 0; i < 12; i++) begin
      w = i % NWORD;
      d = (i < 3) ? 16'hffff : 16'($urandom);
      apb_xfer(1'b1, OFF_EN + 8'(4*w), {16'($urandom), d});
      apb_xfer(1'b0, OFF_EN + 8'(4*w), '0);
      check("no error", 48'(err_seen), '0);
      check("enable rw", 48'(rd),
            48'(d & IMPL_MASK[16*w +: 16]));
    end
    $display("test readback done");
    // unmapped and misaligned places answer with an error
    for (i = 0; i < 3; i++) begin
      apb_xfer(1'b1, bad_addr[i], 32'hffff);
      check("slverr", 48'(err_seen), 48'h1);
      apb_xfer(1'b0, bad_addr[i], '0);
      check("err data", 48'(rd), '0);
    end
    $display("test unmapped done");
    // gating: corner all on, all off, then random
    for (i = 0; i < 8; i++) begin
      for (w = 0; w < NWORD; w++) begin
        en_val[w] = (i == 0) ? 16'hffff : (i == 1) ? 16'h0 : 16'($urandom);
        apb_xfer(1'b1, OFF_EN + 8'(4*w), 32'(en_val[w]));
        apb_xfer(1'b1, OFF_FLAG + 8'(4*w), '0);
      end
      ev = (i < 2) ? '1 : {16'($urandom), 16'($urandom), 16'($urandom)};
      @(posedge clock);
      src_event <= ev;
      @(posedge clock);
      src_event <= '0;
      repeat (3) @(posedge clock);
      check("gated req", irq_req,
            ev & {en_val[2], en_val[1], en_val[0]} & IMPL_MASK);
      apb_xfer(1'b0, OFF_FLAG + 8'h4, '0);
      check("flag word2", 48'(rd), 48'(ev[31:16] & MASK_WORD2));
    end
    $display("test gating done");
    // a source event in the very cycle of a flag clear wins
    d = 16'($urandom) | 16'h0001;
    fork
      apb_xfer(1'b1, OFF_FLAG, '0);
      begin
        repeat (3) @(posedge clock);
        src_event <= {32'h0, d};
        @(posedge clock);
        src_event <= '0;
      end
    join
    apb_xfer(1'b0, OFF_FLAG, '0);
    check("set wins", 48'(rd), 48'(d & MASK_WORD1));
    $display("test set wins done");
    // zero priority blocks despite flag and enable
    en_val[1] = 16'hffff;
    apb_xfer(1'b1, OFF_EN + 8'h4, 32'(en_val[1]));
    @(posedge clock);
    src_event <= '1;
    @(posedge clock);
    src_event <= '0;
    apb_xfer(1'b1, OFF_PRIO, '0);
    apb_xfer(1'b1, OFF_PRIO + 8'h10, 32'h7770);
    apb_xfer(1'b0, OFF_PRIO + 8'h10, '0);
    check("prio rw", 48'(rd), 48'h7770);
    repeat (2) @(posedge clock);
    check("prio gate", irq_req, {en_val[2], en_val[1], en_val[0]}
          & IMPL_MASK & ~48'h1000f);
    $display("test priority done");
    // reset in mid-run clears the enables again
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    apb_xfer(1'b0, OFF_EN + 8'h4, '0);
    check("enable rereset", 48'(rd), '0);
    check("irq rereset", irq_req, '0);
    apb_xfer(1'b0, OFF_PRIO + 8'h10, '0);
    check("prio rereset", 48'(rd), 48'({4{1'b0, PRIO_RESET}}));
    $display("test second reset done");
    // clock enable low freezes the bank
    @(posedge clock);
    ce <= 1'b0;
    src_event <= '1;
    @(posedge clock);
    src_event <= '0;
    @(posedge clock);
    ce <= 1'b1;
    apb_xfer(1'b0, OFF_FLAG + 8'h4, '0);
    check("frozen flag", 48'(rd), '0);
    check("frozen irq", irq_req, '0);
    $display("test clock enable done");
    complete_run();
  end
endmodule // interrupt_enable_bank_tb
`default_nettype wire
